// ===== rtl/bltf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bltf_params.svh"
// Notes on behaviour
// - accept one 10-bit sample per valid strobe, 20 to 40 MHz sample rate.
// - baseline correction comes first and feeds the tail-cancellation shaper.
// - outside the window the running average tracks every incoming sample.
// - trigger freezes the average; held value subtracted throughout the window.
// - baseline moves by ((2^n - 1) old + sample) / 2^n, n programmable.
// - fixed mode subtracts a constant configuration value from each sample.
// - time mode reads pedestal memory at trigger-started counter, quarter-count units.
// - each acquisition subtracts stored pattern values to remove systematic noise.
// - fixed and time subtraction exclusive; either combines with self-calibration.
// - conversion mode outputs memory word addressed by the current sample.
// - conversion runs alongside self-calibration and fixed subtraction.
// - test mode replaces input by memory pattern, fixed pedestal optional.
// - every mode bit combination is accepted: test overrides conversion, conversion and fixed override time.
// - optional polarity inversion as one's complement of each sample.
// - pedestal memory reached by software only through three registers.
// - four cascaded first-order sections; fourth section coefficients stay zero.
// - sections one to three have their own writable, readable zero and pole coefficients; the fourth reads back zero.
// - a bypass option sends corrected samples straight past the shaper.
// - trigger opens a window of at most 1008 samples, counter covers it.
// - coefficients held per channel; one instance serves one channel.
module bltf_top #(
    parameter int DW = 18,
    parameter int CW = 16
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [31:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [31:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    input wire bltf_pkg::bltf_smp_t sample_i,
    input wire logic sample_valid_i,
    input wire logic trig_i,
    output bltf_pkg::bltf_smp_t data_o,
    output logic data_valid_o,
    output logic processing_window_o
);
    import bltf_pkg::*;
    localparam int AW = $bits(bltf_smp_t);
    localparam int FR = `BLTF_SCAL_FRAC;

    bltf_ctrl_t ctrl;
    bltf_smp_t fixed_ped;
    logic [3:0] scal_n;
    logic [AW-1:0] mem_addr;
    logic [10:0] win_len;
    logic [CW-1:0] zero_coef_stage [4];
    logic [CW-1:0] pole_coef_stage [4];
    bltf_win_t win_st;
    logic [10:0] time_cnt;
    logic trig_s1;
    logic trig_s2;
    logic trig_q;
    logic [AW+FR-1:0] acc;
    logic [3:0] scal_eff;
    bltf_smp_t base_int;
    bltf_smp_t x_in;
    bltf_smp_t sc_int;
    bltf_smp_t diff1;
    bltf_smp_t pre_sub;
    logic [11:0] sub_q;
    logic conv_eff;
    logic tdep_eff;
    bltf_smp_t res;
    bltf_smp_t corr;
    logic corr_v;
    logic [4:0] mode_bits;
    logic signed [DW-1:0] sec_in [5];
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [31:0] wv;

    bltf_mem_if #(.AW(AW), .W(AW)) mem_bus ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic signed [DW-1:0] ext(input logic [11:0] v);
        return $signed({{(DW-12){1'b0}}, v});
    endfunction

    function automatic bltf_smp_t clamp_smp(input logic signed [DW-1:0] v);
        if (v < 0) begin
            return '0;
        end
        if (v > ext({2'b00, `BLTF_SMP_MAX})) begin
            return `BLTF_SMP_MAX;
        end
        return v[AW-1:0];
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return a == `BLTF_OFF_CTRL || a == `BLTF_OFF_FIXED || a == `BLTF_OFF_SCALN
            || a == `BLTF_OFF_MADDR || a == `BLTF_OFF_MWDATA || a == `BLTF_OFF_MRDATA
            || a == `BLTF_OFF_WINLEN || a == `BLTF_OFF_STATUS
            || (a[1:0] == 2'h0 && (a[7:4] == `BLTF_OFF_ZERO || a[7:4] == `BLTF_OFF_POLE));
    endfunction

    function automatic logic [31:0] reg_word(input logic [7:0] a);
        logic [31:0] w;
        w = '0;
        case (a)
            `BLTF_OFF_CTRL: w = 32'(ctrl);
            `BLTF_OFF_FIXED: w = 32'(fixed_ped);
            `BLTF_OFF_SCALN: w = 32'(scal_n);
            `BLTF_OFF_MADDR: w = 32'(mem_addr);
            `BLTF_OFF_MRDATA: w = 32'(mem_bus.cfg_rdata);
            `BLTF_OFF_WINLEN: w = 32'(win_len);
            `BLTF_OFF_STATUS: begin
                w = 32'(win_st) | (32'(time_cnt) << `BLTF_ST_TCNT_LSB)
                    | (32'(base_int) << `BLTF_ST_BASE_LSB);
            end
            default: begin
                if (a[1:0] == 2'h0 && a[7:4] == `BLTF_OFF_ZERO) begin
                    w = 32'(zero_coef_stage[a[3:2]]);
                end else if (a[1:0] == 2'h0 && a[7:4] == `BLTF_OFF_POLE) begin
                    w = 32'(pole_coef_stage[a[3:2]]);
                end
            end
        endcase
        return w;
    endfunction

    function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    assign wr_fire = aw_have & w_have & ~s_bvalid_o;
    assign wv = wmask(reg_word(aw_addr_q), w_data_q, w_strb_q);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_awready_o <= 1'b0;
            aw_have <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_awvalid_i && s_awready_o) begin
            s_awready_o <= 1'b0;
            aw_have <= 1'b1;
            aw_addr_q <= s_awaddr_i[7:0];
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end else if (!aw_have && !s_bvalid_o) begin
            s_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_wready_o <= 1'b0;
            w_have <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_wvalid_i && s_wready_o) begin
            s_wready_o <= 1'b0;
            w_have <= 1'b1;
            w_data_q <= s_wdata_i;
            w_strb_q <= s_wstrb_i;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end else if (!w_have && !s_bvalid_o) begin
            s_wready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_bvalid_o <= 1'b0;
            s_bresp_o <= `BLTF_RESP_OKAY;
        end else if (wr_fire) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o <= reg_hit(aw_addr_q) ? `BLTF_RESP_OKAY : `BLTF_RESP_SLVERR;
        end else if (s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_arready_o <= 1'b0;
            s_rvalid_o <= 1'b0;
            s_rdata_o <= '0;
            s_rresp_o <= `BLTF_RESP_OKAY;
        end else if (s_arvalid_i && s_arready_o) begin
            s_arready_o <= 1'b0;
            s_rvalid_o <= 1'b1;
            s_rdata_o <= reg_word(s_araddr_i[7:0]);
            s_rresp_o <= reg_hit(s_araddr_i[7:0]) ? `BLTF_RESP_OKAY : `BLTF_RESP_SLVERR;
        end else if (s_rvalid_o && s_rready_i) begin
            s_rvalid_o <= 1'b0;
        end else if (!s_rvalid_o) begin
            s_arready_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // configuration registers, one coefficient set per channel instance
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl <= bltf_ctrl_t'(`BLTF_CTRL_RST);
            fixed_ped <= '0;
            scal_n <= `BLTF_SCAL_RST;
            mem_addr <= '0;
            win_len <= `BLTF_WIN_MAX;
            for (int i = 0; i < 4; i++) begin
                zero_coef_stage[i] <= '0;
                pole_coef_stage[i] <= '0;
            end
        end else if (wr_fire) begin
            case (aw_addr_q)
                `BLTF_OFF_CTRL: ctrl <= bltf_ctrl_t'(wv[`BLTF_CTRL_W-1:0]);
                `BLTF_OFF_FIXED: fixed_ped <= wv[AW-1:0];
                `BLTF_OFF_SCALN: scal_n <= wv[3:0];
                `BLTF_OFF_MADDR: mem_addr <= wv[AW-1:0];
                `BLTF_OFF_WINLEN: begin
                    // zero or oversize lengths fall back to the longest window
                    if (wv[10:0] == '0 || wv[10:0] > `BLTF_WIN_MAX) begin
                        win_len <= `BLTF_WIN_MAX;
                    end else begin
                        win_len <= wv[10:0];
                    end
                end
                default: begin
                    // stage 4 is never written and stays at zero
                    if (aw_addr_q[1:0] == 2'h0 && aw_addr_q[3:2] != `BLTF_STAGE4) begin
                        if (aw_addr_q[7:4] == `BLTF_OFF_ZERO) begin
                            zero_coef_stage[aw_addr_q[3:2]] <= wv[CW-1:0];
                        end else if (aw_addr_q[7:4] == `BLTF_OFF_POLE) begin
                            pole_coef_stage[aw_addr_q[3:2]] <= wv[CW-1:0];
                        end
                    end
                end
            endcase
        end
    end

    // data write lands one cycle after the bus write
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_bus.cfg_we <= 1'b0;
            mem_bus.cfg_wdata <= '0;
        end else begin
            mem_bus.cfg_we <= wr_fire && aw_addr_q == `BLTF_OFF_MWDATA;
            mem_bus.cfg_wdata <= wv[AW-1:0];
        end
    end
    assign mem_bus.cfg_addr = mem_addr;

    bltf_ped_mem #(.AW(AW), .W(AW)) u_mem (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .mem(mem_bus)
    );

    // ------------------------------------------------------------
    // trigger and processing window
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            trig_s1 <= trig_i;
            trig_s2 <= trig_s1;
            trig_q <= trig_s2;
        end
    end

    // a trigger edge during an open window is ignored
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            win_st <= BLTF_IDLE;
            time_cnt <= '0;
        end else begin
            case (win_st)
                BLTF_IDLE: begin
                    if (trig_s2 && !trig_q) begin
                        win_st <= BLTF_ACTIVE;
                        time_cnt <= '0;
                    end
                end
                BLTF_ACTIVE: begin
                    if (sample_valid_i) begin
                        if (time_cnt == win_len - 11'h001) begin
                            win_st <= BLTF_IDLE;
                        end else begin
                            time_cnt <= time_cnt + 11'h001;
                        end
                    end
                end
                default: win_st <= BLTF_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // self-calibrated baseline
    // ------------------------------------------------------------
    assign scal_eff = (scal_n > 4'(FR)) ? 4'(FR) : scal_n;
    assign base_int = acc[AW+FR-1:FR];

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc <= '0;
        end else if (sample_valid_i && win_st == BLTF_IDLE) begin
            // frozen while the window is open, so the held value is subtracted
            acc <= acc - (acc >> scal_eff) + ({x_in, {FR{1'b0}}} >> scal_eff);
        end
    end

    // ------------------------------------------------------------
    // first baseline correction, one sample per strobe
    // ------------------------------------------------------------
    always_comb begin
        x_in = ctrl.inv ? ~sample_i : sample_i;
        sc_int = ctrl.self ? base_int : '0;
        diff1 = clamp_smp(ext({2'b00, x_in}) - ext({2'b00, sc_int}));
        conv_eff = ctrl.conv & ~ctrl.test;
        tdep_eff = ctrl.tdep & ~ctrl.fixed & ~conv_eff & ~ctrl.test;
        mem_bus.proc_addr = conv_eff ? diff1 : time_cnt[AW-1:0];
        pre_sub = (ctrl.test | conv_eff) ? mem_bus.proc_rdata : diff1;
        // pedestal memory holds quarter counts, the fixed pedestal whole counts
        if (ctrl.fixed) begin
            sub_q = {fixed_ped, 2'b00};
        end else if (tdep_eff) begin
            sub_q = {2'b00, mem_bus.proc_rdata};
        end else begin
            sub_q = '0;
        end
        res = clamp_smp((ext({pre_sub, 2'b00}) - ext(sub_q)) >>> 2);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            corr <= '0;
            corr_v <= 1'b0;
        end else begin
            corr_v <= sample_valid_i;
            if (sample_valid_i) begin
                corr <= res;
            end
        end
    end

    // ------------------------------------------------------------
    // tail-cancellation shaper
    // ------------------------------------------------------------
    assign sec_in[0] = ext({2'b00, corr});

    generate
        for (genvar g = 0; g < 4; g++) begin : g_sec
            bltf_iir_sec #(.DW(DW), .CW(CW)) u_sec (
                .mclk_i(mclk_i),
                .arst_n_i(arst_n_i),
                .en_i(corr_v),
                .x_i(sec_in[g]),
                .zero_i(zero_coef_stage[g]),
                .pole_i(pole_coef_stage[g]),
                .y_o(sec_in[g+1])
            );
        end
    endgenerate

    // bypass trades the four-sample shaper latency for a direct path
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_o <= '0;
            data_valid_o <= 1'b0;
            processing_window_o <= 1'b0;
        end else begin
            data_valid_o <= corr_v;
            processing_window_o <= win_st == BLTF_ACTIVE;
            if (corr_v) begin
                data_o <= ctrl.byp ? corr : clamp_smp(sec_in[4]);
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    assign mode_bits = {ctrl.test, ctrl.conv, ctrl.self, ctrl.tdep, ctrl.fixed};
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_invert_path: assert property (
        sample_valid_i && ctrl.inv && mode_bits == 5'h00 |=> corr == ~$past(sample_i))
        else $error("inverted sample not passed");
    a_fixed_sub: assert property (
        sample_valid_i && mode_bits == 5'h01 && x_in >= fixed_ped
        |=> corr == $past(x_in) - $past(fixed_ped))
        else $error("fixed pedestal not subtracted");
    a_clamp_low: assert property (
        sample_valid_i && mode_bits == 5'h01 && x_in < fixed_ped |=> corr == '0)
        else $error("underflow not clamped");
    a_fixed_wins: assert property (
        sample_valid_i && mode_bits == 5'h03 && x_in >= fixed_ped
        |=> corr == $past(x_in) - $past(fixed_ped))
        else $error("fixed and time subtraction mixed");
    a_avg_track: assert property (
        sample_valid_i && win_st == BLTF_IDLE && scal_n == 4'h0 |=> base_int == $past(x_in))
        else $error("average not tracking outside window");
    a_avg_hold: assert property (
        win_st == BLTF_ACTIVE |=> $stable(acc))
        else $error("baseline moved inside window");
    a_conv_map: assert property (
        mode_bits == 5'h08 |-> mem_bus.proc_addr == x_in)
        else $error("conversion not addressed by sample");
    a_test_pattern: assert property (
        sample_valid_i && mode_bits == 5'h10 |=> corr == $past(mem_bus.proc_rdata))
        else $error("test pattern not injected");
    a_stage4_pass: assert property (
        corr_v |=> sec_in[4] == $past(sec_in[3]))
        else $error("fourth section not neutral");
    a_bypass_out: assert property (
        corr_v && ctrl.byp |=> data_valid_o && data_o == $past(corr))
        else $error("bypass path wrong");
    a_window_bound: assert property (
        win_st == BLTF_ACTIVE |-> time_cnt < win_len)
        else $error("window counter overran");
    a_time_start: assert property (
        win_st == BLTF_IDLE && trig_s2 && !trig_q |=> win_st == BLTF_ACTIVE && time_cnt == '0)
        else $error("window not opened by trigger");
endmodule
`default_nettype wire

// ===== rtl/bltf_params.svh
`ifndef BLTF_PARAMS_SVH
`define BLTF_PARAMS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define BLTF_OFF_CTRL 8'h00
`define BLTF_OFF_FIXED 8'h04
`define BLTF_OFF_SCALN 8'h08
`define BLTF_OFF_MADDR 8'h0C
`define BLTF_OFF_MWDATA 8'h10
`define BLTF_OFF_MRDATA 8'h14
`define BLTF_OFF_WINLEN 8'h18
`define BLTF_OFF_STATUS 8'h1C
// coefficient banks: high nibble selects bank, bits 3:2 the stage
`define BLTF_OFF_ZERO 4'h2
`define BLTF_OFF_POLE 4'h3
`define BLTF_STAGE4 2'h3
// ------------------------------------------------------------
// fields, reset values and limits
// ------------------------------------------------------------
`define BLTF_CTRL_W 7
`define BLTF_CTRL_RST 7'h00
`define BLTF_ST_TCNT_LSB 4
`define BLTF_ST_BASE_LSB 16
`define BLTF_WIN_MAX 11'h3F0
`define BLTF_SMP_MAX 10'h3FF
`define BLTF_SCAL_FRAC 8
`define BLTF_SCAL_RST 4'h4
`define BLTF_RESP_OKAY 2'h0
`define BLTF_RESP_SLVERR 2'h2
`endif

// ===== rtl/bltf_pkg.sv
package bltf_pkg;
    typedef logic [9:0] bltf_smp_t;
    typedef enum logic [0:0] {
        BLTF_IDLE = 1'b0,
        BLTF_ACTIVE = 1'b1
    } bltf_win_t;
    // bit 0 is fixed subtraction, bit 6 the shaper bypass
    typedef struct packed {
        logic byp;
        logic inv;
        logic test;
        logic conv;
        logic self;
        logic tdep;
        logic fixed;
    } bltf_ctrl_t;
endpackage

// ===== rtl/bltf_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bltf_mem_if #(
    parameter int AW = 10,
    parameter int W = 10
);
    logic [AW-1:0] proc_addr;
    logic [W-1:0] proc_rdata;
    logic [AW-1:0] cfg_addr;
    logic [W-1:0] cfg_wdata;
    logic cfg_we;
    logic [W-1:0] cfg_rdata;
    modport core (output proc_addr, cfg_addr, cfg_wdata, cfg_we, input proc_rdata, cfg_rdata);
    modport store (input proc_addr, cfg_addr, cfg_wdata, cfg_we, output proc_rdata, cfg_rdata);
endinterface
`default_nettype wire

// ===== rtl/bltf_ped_mem.sv
`timescale 1ns/1ps
`default_nettype none
module bltf_ped_mem #(
    parameter int AW = 10,
    parameter int W = 10
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    bltf_mem_if.store mem
);
    import bltf_pkg::*;
    logic [W-1:0] store [2**AW];

    // one write port for software, two combinational read ports
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 2**AW; i++) begin
                store[i] <= '0;
            end
        end else if (mem.cfg_we) begin
            store[mem.cfg_addr] <= mem.cfg_wdata;
        end
    end

    assign mem.proc_rdata = store[mem.proc_addr];
    assign mem.cfg_rdata = store[mem.cfg_addr];
endmodule
`default_nettype wire

// ===== rtl/bltf_iir_sec.sv
`timescale 1ns/1ps
`default_nettype none
module bltf_iir_sec #(
    parameter int DW = 18,
    parameter int CW = 16
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic signed [DW-1:0] x_i,
    input wire logic [CW-1:0] zero_i,
    input wire logic [CW-1:0] pole_i,
    output logic signed [DW-1:0] y_o
);
    import bltf_pkg::*;
    logic signed [DW-1:0] x_prev;
    logic signed [DW+CW:0] zero_prod;
    logic signed [DW+CW:0] pole_prod;
    logic signed [DW-1:0] next_y;

    // coefficients are unsigned fractions, all CW bits below the point
    always_comb begin
        zero_prod = $signed({1'b0, zero_i}) * x_prev;
        pole_prod = $signed({1'b0, pole_i}) * y_o;
        next_y = x_i - DW'(zero_prod >>> CW) + DW'(pole_prod >>> CW);
    end

    // no saturation inside the cascade: headroom comes from DW
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            x_prev <= '0;
            y_o <= '0;
        end else if (en_i) begin
            x_prev <= x_i;
            y_o <= next_y;
        end
    end
endmodule
`default_nettype wire

// ===== tb/bltf_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// converter model: a sample every second clock, 25 MHz rate
// --------------------------------------------
module bltf_adc_model (
    input wire logic mclk_i,
    input wire logic en_i,
    output logic [9:0] sample_o,
    output logic valid_o
);
    logic [31:0] st = 32'hf00d_8c9f;
    initial valid_o = 1'b0;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // sample bits change every cycle, so nothing rides on a stale value
    always @(posedge mclk_i) begin
        st <= xs(st);
        valid_o <= en_i && !valid_o;
        sample_o <= st[9:0];
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bltf_pkg::*;
    logic mclk_i = 0, arst_n_i = 0, en = 0, trig = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, sv, dv, win;
    logic [1:0] bresp, rresp;
    bltf_smp_t smp, dout;
    logic [9:0] q[$];
    logic [6:0] mode = 0;
    int errors = 0, checked = 0, cyc = 0;
    int wcnt = 0, e, hp[6];
    logic sv_d = 0;
    logic [9:0] px = 0;
    localparam int ZK = 32'h0000_1234;
    bltf_top i_bltf_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .s_awaddr_i(awaddr),
        .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(4'hf),
        .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
        .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
        .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
        .s_rready_i(rready), .sample_i(smp), .sample_valid_i(sv), .trig_i(trig),
        .data_o(dout), .data_valid_o(dv), .processing_window_o(win));
    bltf_adc_model i_bltf_adc_model (.mclk_i(mclk_i), .en_i(en), .sample_o(smp), .valid_o(sv));
    initial forever #10 mclk_i = ~mclk_i;
    // --------------------------------------------
    // checking
    // --------------------------------------------
    task automatic test_done;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // fixed pedestal is 10'h100, memory word is address xor 10'h155
    function automatic logic [9:0] expv(input logic [9:0] s);
        logic [9:0] x;
        int v;
        x = mode[5] ? ~s : s;
        // self-calibration is run with n = 0, so the baseline is the last sample
        v = int'(x) - (mode[2] ? int'(px) : 0);
        x = v < 0 ? 10'h000 : 10'(v);
        if (mode[3]) x = x ^ 10'h155;
        // test pattern is read at time counter 0, before any window
        if (mode[4]) x = 10'h155;
        v = int'(x) - (mode[0] ? 256 : 0);
        return v < 0 ? 10'h000 : 10'(v);
    endfunction
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        sv_d <= sv;
        if (sv_d && win) wcnt <= wcnt + 1;
        if (sv) begin
            q.push_back(expv(smp));
            px = mode[5] ? ~smp : smp;
        end
        if (dv && q.size() > 0) begin
            for (int i = 5; i > 0; i--) hp[i] = hp[i-1];
            hp[0] = q.pop_front();
            // shaper on: only the stage 1 zero term acts, four samples late
            e = hp[4] - ((ZK * hp[5]) >>> 16);
            cmp(dout, mode[6] ? hp[0] : (e < 0 ? 0 : e));
        end
        if (cyc == 40000) begin
            errors++;
            test_done();
        end
    end
    // --------------------------------------------
    // bus master
    // --------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp({30'h0, bresp}, {30'h0, r});
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        cmp(rdata, e);
        cmp({30'h0, rresp}, {30'h0, r});
        @(posedge mclk_i);
    endtask
    // stream is stopped and drained first so no sample straddles a mode change
    task automatic run(input logic [6:0] m);
        en <= 1'b0;
        repeat (4) @(posedge mclk_i);
        mode = m;
        wr(8'h00, {25'h0, m}, 2'h0);
        q.delete();
        en <= 1'b1;
        repeat (300) @(posedge mclk_i);
        $display("mode %h done", m);
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(8'h08, 32'h0000_0004, 2'h0);
        rd(8'h18, 32'h0000_03f0, 2'h0);
        rd(8'h40, 32'h0000_0000, 2'h2);
        wr(8'h20, 32'h0000_1234, 2'h0);
        rd(8'h20, 32'h0000_1234, 2'h0);
        wr(8'h2c, 32'h0000_1234, 2'h0);
        rd(8'h2c, 32'h0000_0000, 2'h0);
        for (int a = 0; a < 1024; a++) begin
            wr(8'h0c, a, 2'h0);
            wr(8'h10, a ^ 32'h0000_0155, 2'h0);
        end
        wr(8'h0c, 32'h0000_002a, 2'h0);
        rd(8'h14, 32'h0000_017f, 2'h0);
        wr(8'h04, 32'h0000_0100, 2'h0);
        run(7'h41);
        run(7'h61);
        run(7'h48);
        run(7'h49);
        run(7'h50);
        wr(8'h08, 32'h0000_0000, 2'h0);
        run(7'h43);
        run(7'h44);
        run(7'h01);
        run(7'h20);
        wr(8'h18, 32'h0000_000a, 2'h0);
        trig <= 1'b1;
        repeat (60) @(posedge mclk_i);
        trig <= 1'b0;
        cmp(wcnt, 32'h0000_000a);
        cmp(win, 32'h0000_0000);
        $display("window test done");
        $display("stream tests done");
        test_done();
    end
endmodule
`default_nettype wire
